// ### apt_pkg.sv
// Shared constants for the auto-reload pwm timer
`default_nettype none
package apt_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PRE_W = 7;
  localparam int DIV_W = 3;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CH_N = 4;
  localparam int CAP_N = 2;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_PWMCTL = 8'h0C;
  localparam logic [7:0] OFS_DUTY0 = 8'h10;
  localparam logic [7:0] OFS_CAPCTL = 8'h20;
  localparam logic [7:0] OFS_CAP0 = 8'h24;
  localparam logic [7:0] OFS_STEP = 8'h04;

  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int CTL_EXTCLK = 7;
  localparam int CTL_DIV_LO = 4;
  localparam int CTL_RUN = 3;
  localparam int CTL_FORCE = 2;
  localparam int CTL_WIRQ = 1;
  localparam int CTL_WFLAG = 0;

  // Pulse control and capture control fields
  localparam int PWM_OE_LO = 4;
  localparam int PWM_POL_LO = 0;
  localparam int CAP_SENS_LO = 4;
  localparam int CAP_IE_LO = 2;
  localparam int CAP_FLAG_LO = 0;

  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [6:0] PRE_RST = 7'h00;

endpackage
`default_nettype wire

// ### apt_sync_edge.sv
// Two-stage synchroniser with rising and falling edge detect
`timescale 1ns/10ps
`default_nettype none
module apt_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic clock,              // System clock
  input wire logic rst,                // Async reset, high
  input wire logic [WIDTH-1:0] din,    // Raw pin levels
  output logic [WIDTH-1:0] level,      // Synchronised level
  output logic [WIDTH-1:0] rise,       // One-cycle rising pulse
  output logic [WIDTH-1:0] fall        // One-cycle falling pulse
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // Stage one feeds stage two only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Edge pulses from settled stages
  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;

endmodule
`default_nettype wire

// ### apt_prescaler.sv
// Seven-bit prescaler with power-of-two tap select
`timescale 1ns/10ps
`default_nettype none
module apt_prescaler (
  input wire logic clock,                          // System clock
  input wire logic rst,                            // Async reset, high
  input wire logic run,                            // Count enable
  input wire logic srcTick,                        // Input clock event
  input wire logic clear,                          // Restart from zero
  input wire logic [apt_pkg::DIV_W-1:0] divSel,    // Tap select
  output logic countTick                           // Counter advance pulse
);

  logic [apt_pkg::PRE_W-1:0] pre_ff;
  logic tapFull;

  // Tap reached when the low divSel bits are all ones
  always_comb begin
    tapFull = 1'b1;
    for (int i = 0; i < apt_pkg::PRE_W; i++) begin
      if (i < int'(divSel) && !pre_ff[i]) begin
        tapFull = 1'b0;
      end
    end
  end

  // (R02) ratio two to the divSel
  assign countTick = run & srcTick & tapFull;

  // (R03) frozen while not running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_ff <= apt_pkg::PRE_RST;
    end else if (clear) begin
      pre_ff <= apt_pkg::PRE_RST;
    end else if (run && srcTick) begin
      pre_ff <= pre_ff + 7'h01;
    end
  end

endmodule
`default_nettype wire

// ### apt_timer.sv
// Auto-reload pwm timer with capture, APB register slave
// Operation
// (R01) External clock select picks prescaler source
// (R02) Divide by two to divider select
// (R03) Run bit clear freezes prescaler, counter
// (R04) Force reload bit reads back zero
// (R05) Force reload loads reload, clears prescaler
// (R06) Wrap irq only when flag and enable
// (R07) Flag sets on wrap from FFh
// (R08) Control register read clears wrap flag
// (R09) Counter register reads live, writes load
// (R10) Wrap reloads counter from reload value
// (R11) Wrap sets outputs to start level
// (R12) Period is 256 minus reload value
// (R13) Enable bits connect each output
// (R14) Polarity picks level versus compare
// (R15) Polarity change acts at once
// (R16) Duty register gives second edge
// (R17) Capture control top bits read zero
// (R18) Sensitivity bit selects capture edge
// (R19) Per-channel capture irq enable
// (R20) Capture flag cleared by value read
// (R21) Capture value latched, read only
// (R22) All registers reset to zero
// (R23) Compare shadow loads only at wrap
// (R24) Compare match restores opposite level
// (R25) Capture blocked until value read
// (R26) Pins synchronised and edge detected
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module apt_timer (
  input wire logic clock,                             // 125 MHz clock
  input wire logic rst,                               // Async reset, high
  input wire logic psel,                              // APB select
  input wire logic penable,                           // APB access phase
  input wire logic pwrite,                            // APB write
  input wire logic [apt_pkg::ADDR_W-1:0] paddr,       // APB byte address
  input wire logic [apt_pkg::DATA_W-1:0] pwdata,      // APB write data
  output logic [apt_pkg::DATA_W-1:0] prdata,          // APB read data
  output logic pready,                                // APB ready
  output logic pslverr,                               // APB error
  input wire logic extClockIn,                        // External count clock
  input wire logic [apt_pkg::CAP_N-1:0] captureIn,    // Capture pins
  output logic [apt_pkg::CH_N-1:0] pulseOut,          // Pulse outputs
  output logic [apt_pkg::CH_N-1:0] pulseOe,           // Pulse pin enables
  output logic wrapIrq,                               // Wrap interrupt
  output logic [apt_pkg::CAP_N-1:0] captureIrq        // Capture interrupts
);

  localparam int CH = apt_pkg::CH_N;
  localparam int CP = apt_pkg::CAP_N;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [7:0] idxOfs(input logic [7:0] base, input int idx);
    idxOfs = base + 8'(idx * 4);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic extSel_ff;
  logic [apt_pkg::DIV_W-1:0] divSel_ff;
  logic run_ff;
  logic wrapIe_ff;
  logic wrapFlag_ff;
  logic [7:0] count_ff;
  logic [7:0] reload_ff;
  logic [CH-1:0] oe_ff;
  logic [CH-1:0] pol_ff;
  logic [7:0] duty_ff [CH];
  logic [7:0] shadow_ff [CH];
  logic [CP-1:0] sens_ff;
  logic [CP-1:0] capIe_ff;
  logic [CP-1:0] capFlag_ff;
  logic [7:0] capVal_ff [CP];
  logic [CP-1:0] capSnap_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [CH-1:0] pulseOut_ff;
  logic [CH-1:0] pulseOe_ff;
  logic wrapIrq_ff;
  logic [CP-1:0] captureIrq_ff;

  logic setupPh;
  logic accessPh;
  logic wrAcc;
  logic rdAcc;
  logic mapped;
  logic [31:0] rdMux;
  logic wrCtrl;
  logic wrCnt;
  logic forceLoad;
  logic extRise;
  logic srcTick;
  logic countTick;
  logic wrapEvt;
  logic [CP-1:0] capRise;
  logic [CP-1:0] capFall;
  logic [CP-1:0] capEdge;
  logic [CP-1:0] capRead;
  logic [7:0] nxt_count;
  logic [7:0] nxt_shadow [CH];
  logic [CH-1:0] nxt_pol;
  logic [CH-1:0] nxt_oe;
  logic nxt_wrapFlag;
  logic nxt_wrapIe;
  logic [CP-1:0] nxt_capFlag;
  logic [CP-1:0] nxt_capIe;

  // ----------------------------------------
  // APB phases
  // ----------------------------------------
  // Ready is registered, so every transfer takes one access cycle
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable & pready_ff;
  assign wrAcc = accessPh & pwrite & mapped;
  assign rdAcc = accessPh & ~pwrite;
  assign wrCtrl = wrAcc & hit(paddr, apt_pkg::OFS_CTRL);
  assign wrCnt = wrAcc & hit(paddr, apt_pkg::OFS_CNT);
  // (R05) one-shot load request
  assign forceLoad = wrCtrl & pwdata[apt_pkg::CTL_FORCE];

  // Read mux and map check
  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, apt_pkg::OFS_CTRL)) begin
      // (R04) force bit reads zero
      rdMux[7:0] = {extSel_ff, divSel_ff, run_ff, 1'b0, wrapIe_ff, wrapFlag_ff};
    end else if (hit(paddr, apt_pkg::OFS_CNT)) begin
      // (R09) live counter value
      rdMux[7:0] = count_ff;
    end else if (hit(paddr, apt_pkg::OFS_RELOAD)) begin
      rdMux[7:0] = reload_ff;
    end else if (hit(paddr, apt_pkg::OFS_PWMCTL)) begin
      rdMux[7:0] = {oe_ff, pol_ff};
    end else if (hit(paddr, apt_pkg::OFS_CAPCTL)) begin
      // (R17) top two bits zero
      rdMux[7:0] = {2'b00, sens_ff, capIe_ff, capFlag_ff};
    end else begin
      mapped = 1'b0;
      for (int i = 0; i < CH; i++) begin
        if (hit(paddr, idxOfs(apt_pkg::OFS_DUTY0, i))) begin
          rdMux[7:0] = duty_ff[i];
          mapped = 1'b1;
        end
      end
      for (int i = 0; i < CP; i++) begin
        if (hit(paddr, idxOfs(apt_pkg::OFS_CAP0, i))) begin
          rdMux[7:0] = capVal_ff[i];
          mapped = 1'b1;
        end
      end
    end
  end

  // Bus answer; data snapshot taken in setup, held through access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setupPh;
      if (setupPh) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr_ff <= ~mapped;
      end else if (accessPh) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  // (R26) pins settle before use
  apt_sync_edge #(.WIDTH(1)) u_extSync (
    .clock(clock),
    .rst(rst),
    .din(extClockIn),
    .level(),
    .rise(extRise),
    .fall()
  );

  // (R01) cpu clock counts every cycle
  assign srcTick = extSel_ff ? extRise : 1'b1;

  // (R05) counter writes also restart the prescaler
  apt_prescaler u_pre (
    .clock(clock),
    .rst(rst),
    .run(run_ff),
    .srcTick(srcTick),
    .clear(forceLoad | wrCnt),
    .divSel(divSel_ff),
    .countTick(countTick)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // (R07) wrap from maximum only
  assign wrapEvt = countTick & (count_ff == apt_pkg::CNT_MAX) & ~wrCnt & ~forceLoad;

  // Next count: software load wins over counting
  always_comb begin
    nxt_count = count_ff;
    if (wrCnt) begin
      // (R09) immediate load, counting goes on
      nxt_count = pwdata[7:0];
    end else if (forceLoad) begin
      nxt_count = reload_ff;
    end else if (wrapEvt) begin
      // (R10) (R12) reload sets the period
      nxt_count = reload_ff;
    end else if (countTick) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= apt_pkg::REG_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // (R22) everything clears at reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      extSel_ff <= 1'b0;
      divSel_ff <= '0;
      run_ff <= 1'b0;
      wrapIe_ff <= 1'b0;
      reload_ff <= apt_pkg::REG_RST;
      oe_ff <= '0;
      pol_ff <= '0;
      sens_ff <= '0;
      capIe_ff <= '0;
    end else begin
      if (wrCtrl) begin
        extSel_ff <= pwdata[apt_pkg::CTL_EXTCLK];
        divSel_ff <= pwdata[apt_pkg::CTL_DIV_LO +: apt_pkg::DIV_W];
        run_ff <= pwdata[apt_pkg::CTL_RUN];
      end
      wrapIe_ff <= nxt_wrapIe;
      if (wrAcc && hit(paddr, apt_pkg::OFS_RELOAD)) begin
        reload_ff <= pwdata[7:0];
      end
      oe_ff <= nxt_oe;
      pol_ff <= nxt_pol;
      capIe_ff <= nxt_capIe;
      if (wrAcc && hit(paddr, apt_pkg::OFS_CAPCTL)) begin
        sens_ff <= pwdata[apt_pkg::CAP_SENS_LO +: CP];
      end
    end
  end

  // Enables seen by the registered outputs in the same edge
  assign nxt_wrapIe = wrCtrl ? pwdata[apt_pkg::CTL_WIRQ] : wrapIe_ff;
  assign nxt_capIe = (wrAcc && hit(paddr, apt_pkg::OFS_CAPCTL)) ?
                     pwdata[apt_pkg::CAP_IE_LO +: CP] : capIe_ff;

  // (R13) (R15) new enable and polarity act on this write
  always_comb begin
    nxt_oe = oe_ff;
    nxt_pol = pol_ff;
    if (wrAcc && hit(paddr, apt_pkg::OFS_PWMCTL)) begin
      nxt_oe = pwdata[apt_pkg::PWM_OE_LO +: CH];
      nxt_pol = pwdata[apt_pkg::PWM_POL_LO +: CH];
    end
  end

  // ----------------------------------------
  // Wrap flag
  // ----------------------------------------
  // (R08) clear only a flag the read really returned; set wins
  always_comb begin
    nxt_wrapFlag = wrapFlag_ff;
    if (rdAcc && hit(paddr, apt_pkg::OFS_CTRL) && prdata_ff[apt_pkg::CTL_WFLAG]) begin
      nxt_wrapFlag = 1'b0;
    end
    if (wrapEvt) begin
      nxt_wrapFlag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrapFlag_ff <= 1'b0;
    end else begin
      wrapFlag_ff <= nxt_wrapFlag;
    end
  end

  // ----------------------------------------
  // Pulse channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : gChan
      // (R16) duty register per channel
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          duty_ff[g] <= apt_pkg::REG_RST;
        end else if (wrAcc && hit(paddr, idxOfs(apt_pkg::OFS_DUTY0, g))) begin
          duty_ff[g] <= pwdata[7:0];
        end
      end

      // (R23) shadow follows duty only on wrap
      assign nxt_shadow[g] = wrapEvt ? duty_ff[g] : shadow_ff[g];

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          shadow_ff[g] <= apt_pkg::REG_RST;
        end else begin
          shadow_ff[g] <= nxt_shadow[g];
        end
      end

      // Output level from next values, so the pin moves with the counter
      // (R11) (R14) (R24) start level to compare, opposite above it
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pulseOut_ff[g] <= 1'b0;
          pulseOe_ff[g] <= 1'b0;
        end else begin
          // (R13) disconnected channel drives low, enable off
          pulseOut_ff[g] <= nxt_oe[g] & ((nxt_count <= nxt_shadow[g]) ^ nxt_pol[g]);
          pulseOe_ff[g] <= nxt_oe[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Capture channels
  // ----------------------------------------
  // (R26) capture pins synchronised
  apt_sync_edge #(.WIDTH(CP)) u_capSync (
    .clock(clock),
    .rst(rst),
    .din(captureIn),
    .level(),
    .rise(capRise),
    .fall(capFall)
  );

  generate
    for (g = 0; g < CP; g++) begin : gCap
      // (R18) edge choice per channel
      assign capEdge[g] = sens_ff[g] ? capRise[g] : capFall[g];
      // (R20) value read clears a flag seen at setup
      assign capRead[g] = rdAcc & hit(paddr, idxOfs(apt_pkg::OFS_CAP0, g)) & capSnap_ff[g];

      // Read clear wins; an edge while the flag is set is dropped
      always_comb begin
        nxt_capFlag[g] = capFlag_ff[g];
        if (capRead[g]) begin
          nxt_capFlag[g] = 1'b0;
        end
        if (capEdge[g] && !capFlag_ff[g]) begin
          nxt_capFlag[g] = 1'b1;
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          capFlag_ff[g] <= 1'b0;
          capVal_ff[g] <= apt_pkg::REG_RST;
          capSnap_ff[g] <= 1'b0;
        end else begin
          capFlag_ff[g] <= nxt_capFlag[g];
          // (R21) (R25) latch only while no capture pending
          if (capEdge[g] && !capFlag_ff[g]) begin
            capVal_ff[g] <= count_ff;
          end
          if (setupPh) begin
            capSnap_ff[g] <= capFlag_ff[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  // (R06) (R19) masked by their enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrapIrq_ff <= 1'b0;
      captureIrq_ff <= '0;
    end else begin
      wrapIrq_ff <= nxt_wrapFlag & nxt_wrapIe;
      captureIrq_ff <= nxt_capFlag & nxt_capIe;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pulseOut = pulseOut_ff;
  assign pulseOe = pulseOe_ff;
  assign wrapIrq = wrapIrq_ff;
  assign captureIrq = captureIrq_ff;

endmodule
`default_nettype wire

// ### apt_timer_sva.sv
// Port checker for the auto-reload pwm timer
`timescale 1ns/10ps
`default_nettype none
module apt_timer_sva (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [apt_pkg::ADDR_W-1:0] paddr, // Address
  input wire logic [apt_pkg::DATA_W-1:0] pwdata, // Write data
  input wire logic [apt_pkg::DATA_W-1:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [apt_pkg::CH_N-1:0] pulseOut, // Levels
  input wire logic [apt_pkg::CH_N-1:0] pulseOe, // Enables
  input wire logic wrapIrq, // Wrap irq
  input wire logic [apt_pkg::CAP_N-1:0] captureIrq // Capture irqs
);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic rdAcc;
  logic rdSetup;
  logic [3:0] oeReq;
  // Setup strobe marks the moment the flag snapshot is taken
  assign rdAcc = pready && !pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign oeReq = pwdata[7:4];

  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  property p_forceZero;
    rdAcc && paddr == apt_pkg::OFS_CTRL |-> !prdata[apt_pkg::CTL_FORCE];
  endproperty
  a_forceZero: assert property (p_forceZero) else $error("force bit read as one");
  property p_capTop;
    rdAcc && paddr == apt_pkg::OFS_CAPCTL |-> prdata[7:6] == 2'h0;
  endproperty
  a_capTop: assert property (p_capTop) else $error("capture top bits set");
  // Flag still set during the access, so irq must agree with the read
  property p_wrapMask;
    rdAcc && paddr == apt_pkg::OFS_CTRL |-> (prdata[1] || !wrapIrq)
      && (!(prdata[1] && prdata[0]) || wrapIrq);
  endproperty
  a_wrapMask: assert property (p_wrapMask) else $error("wrap irq mask wrong");
  property p_capMask;
    rdAcc && paddr == apt_pkg::OFS_CAPCTL |-> (captureIrq & ~prdata[3:2]) == 2'h0;
  endproperty
  a_capMask: assert property (p_capMask) else $error("capture irq unmasked");
  property p_oeGate;
    (pulseOut & ~pulseOe) == 4'h0;
  endproperty
  a_oeGate: assert property (p_oeGate) else $error("disabled channel driven");
  property p_oeWrite;
    pready && pwrite && paddr == apt_pkg::OFS_PWMCTL |=> pulseOe == $past(oeReq);
  endproperty
  a_oeWrite: assert property (p_oeWrite) else $error("enable write lost");
  // Stopped counter cannot wrap again, so the clear must show
  property p_wrapClear;
    rdAcc && paddr == apt_pkg::OFS_CTRL && prdata[1:0] == 2'h3 && !prdata[apt_pkg::CTL_RUN]
      |=> !wrapIrq;
  endproperty
  a_wrapClear: assert property (p_wrapClear) else $error("wrap flag not cleared");
  property p_capClear;
    rdSetup && paddr == apt_pkg::OFS_CAP0 && captureIrq[0] |-> ##2 !captureIrq[0];
  endproperty
  a_capClear: assert property (p_capClear) else $error("capture flag not cleared");
  property p_resetOut;
    $fell(rst) |-> pulseOe == 4'h0 && pulseOut == 4'h0 && !wrapIrq && captureIrq == 2'h0;
  endproperty
  a_resetOut: assert property (p_resetOut) else $error("output set after reset");
  // Main scenarios reached
  c_wrap: cover property (wrapIrq);
  c_cap: cover property (captureIrq == 2'h3);
  c_err: cover property (pready && pslverr);
endmodule
bind apt_timer apt_timer_sva u_sva (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulseOut(pulseOut), .pulseOe(pulseOe), .wrapIrq(wrapIrq),
  .captureIrq(captureIrq));
`default_nettype wire

// ### apt_testbench.sv
// Self-checking testbench for the auto-reload pwm timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ------------------------------------------------
  // Signals and design
  // ------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic extClockIn = 1'b0;
  logic [1:0] captureIn = 2'h3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pulseOut;
  logic [3:0] pulseOe;
  logic wrapIrq;
  logic [1:0] captureIrq;
  logic [31:0] rdData;
  logic rdErr;
  int mismatches = 0;
  int checkCount = 0;
  // Free running 8 ns clock
  always #4 clock = ~clock;
  apt_timer uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClockIn(extClockIn), .captureIn(captureIn), .pulseOut(pulseOut),
    .pulseOe(pulseOe), .wrapIrq(wrapIrq), .captureIrq(captureIrq));

  // ------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------
  task automatic tally_and_finish;
    $display("TB: checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic checkPin(input logic [3:0] got, input logic [3:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clock);
      n++;
    end
    if (n == 16) mismatches++;
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, 32'(d));
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    checkReg(rdData, 32'(e));
  endtask
  // Capture pins move, then the synchroniser gets time to settle
  task automatic edgeTo(input logic [1:0] lv);
    captureIn <= lv;
    tick(8);
  endtask
  // Cycles at level one over two whole periods, phase does not matter
  function automatic logic [15:0] hiExp(logic [7:0] d, logic [7:0] r, logic pl, logic en);
    logic [15:0] h;
    h = 16'h0002 * (16'(d) - 16'(r) + 16'h0001);
    if (pl) h = 16'h0002 * (16'h0100 - 16'(r)) - h;
    return en ? h : 16'h0000;
  endfunction

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] r;
    logic [7:0] v;
    logic [7:0] d[4];
    logic [3:0] oe;
    logic [3:0] pol;
    logic [1:0] sens;
    logic [15:0] hi[4];
    void'($urandom(49));
    tick(3);
    rst <= 1'b0;
    for (int a = 0; a <= 40; a += 4) rdChk(8'(a), 8'h00);
    xfer(1'b0, 8'h40, 32'h0000_0000);
    checkReg({rdErr, rdData[30:0]}, 32'h8000_0000);
    $display("TB: reset test done");
    r = 8'($urandom);
    v = r ^ 8'h5A;
    wr(apt_pkg::OFS_RELOAD, r);
    wr(apt_pkg::OFS_CNT, v);
    tick(20);
    rdChk(apt_pkg::OFS_CNT, v);
    wr(apt_pkg::OFS_CTRL, 8'h04);
    rdChk(apt_pkg::OFS_CTRL, 8'h00);
    rdChk(apt_pkg::OFS_CNT, r);
    // Every divider code; the stop write lands three cycles late
    for (int n = 0; n < 8; n++) begin
      wr(apt_pkg::OFS_CNT, 8'h00);
      wr(apt_pkg::OFS_CTRL, 8'(n << 4) | 8'h08);
      tick(40 << n);
      wr(apt_pkg::OFS_CTRL, 8'(n << 4));
      xfer(1'b0, apt_pkg::OFS_CNT, 32'h0000_0000);
      v = 8'(((40 << n) + 3) >> n);
      checkReg(32'(rdData[7:0] + 8'h01 - v <= 8'h02), 32'h0000_0001);
    end
    wr(apt_pkg::OFS_CNT, 8'h10);
    wr(apt_pkg::OFS_CTRL, 8'h88);
    repeat (10) begin
      tick(4);
      extClockIn <= 1'b1;
      tick(4);
      extClockIn <= 1'b0;
    end
    tick(8);
    wr(apt_pkg::OFS_CTRL, 8'h00);
    rdChk(apt_pkg::OFS_CNT, 8'h1A);
    $display("TB: clock test done");
    r = 8'($urandom_range(200));
    wr(apt_pkg::OFS_RELOAD, r);
    wr(apt_pkg::OFS_CNT, 8'hFF);
    wr(apt_pkg::OFS_CTRL, 8'h78);
    tick(150);
    checkPin({3'h0, wrapIrq}, 4'h0);
    wr(apt_pkg::OFS_CTRL, 8'h73);
    tick(2);
    checkPin({3'h0, wrapIrq}, 4'h1);
    rdChk(apt_pkg::OFS_CNT, r);
    rdChk(apt_pkg::OFS_CTRL, 8'h73);
    rdChk(apt_pkg::OFS_CTRL, 8'h72);
    $display("TB: wrap test done");
    r = 8'($urandom_range(100));
    oe = 4'($urandom) | 4'h8;
    pol = 4'($urandom);
    wr(apt_pkg::OFS_RELOAD, r);
    for (int i = 0; i < 4; i++) begin
      d[i] = (i == 3) ? 8'hFF : r + 8'h01 + 8'($urandom_range(150));
      wr(apt_pkg::OFS_DUTY0 + 8'(4 * i), d[i]);
    end
    wr(apt_pkg::OFS_PWMCTL, {oe, pol});
    wr(apt_pkg::OFS_CTRL, 8'h08);
    tick(300);
    checkPin(pulseOe, oe);
    // Second pass runs with every polarity turned round
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) hi[i] = 16'h0000;
      repeat (2 * (256 - int'(r))) begin
        @(posedge clock);
        for (int i = 0; i < 4; i++) hi[i] += 16'(pulseOut[i]);
      end
      for (int i = 0; i < 4; i++) begin
        checkReg(32'(hi[i]), 32'(hiExp(d[i], r, pol[i], oe[i])));
      end
      pol = ~pol;
      wr(apt_pkg::OFS_PWMCTL, {oe, pol});
      tick(2);
    end
    $display("TB: pulse test done");
    sens = 2'($urandom);
    v = 8'($urandom);
    r = v ^ 8'hC3;
    wr(apt_pkg::OFS_CTRL, 8'h00);
    wr(apt_pkg::OFS_CNT, v);
    wr(apt_pkg::OFS_CAPCTL, {2'h0, sens, 4'hC});
    edgeTo(~sens);
    edgeTo(sens);
    checkPin({2'h0, captureIrq}, 4'h3);
    rdChk(apt_pkg::OFS_CAPCTL, {2'h0, sens, 4'hF});
    wr(apt_pkg::OFS_CNT, r);
    edgeTo(~sens);
    edgeTo(sens);
    wr(apt_pkg::OFS_CAP0, 8'hFF);
    rdChk(apt_pkg::OFS_CAP0, v);
    rdChk(apt_pkg::OFS_CAP0 + 8'h04, v);
    tick(2);
    checkPin({2'h0, captureIrq}, 4'h0);
    edgeTo(~sens);
    checkPin({2'h0, captureIrq}, 4'h0);
    wr(apt_pkg::OFS_CAPCTL, {2'h0, sens, 4'h0});
    edgeTo(sens);
    checkPin({2'h0, captureIrq}, 4'h0);
    rdChk(apt_pkg::OFS_CAPCTL, {2'h0, sens, 4'h3});
    rdChk(apt_pkg::OFS_CAP0, r);
    $display("TB: capture test done");
    tally_and_finish();
  end
  // Watchdog well past the expected run length
  initial begin
    #480000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
